// >>> core/disp_cmd_pkg.sv
/*
  Codes, counts, reset values and colour codes of the command decoder.
  Assumes one byte per strobe.
*/
package disp_cmd_pkg;

  localparam logic [7:0] CMD_LINK_ERR   = 8'h05;
  localparam logic [7:0] CMD_PIX_RED    = 8'h06;
  localparam logic [7:0] CMD_PIX_GREEN  = 8'h07;
  localparam logic [7:0] CMD_PIX_BLUE   = 8'h08;
  localparam logic [7:0] CMD_STATUS     = 8'h09;
  localparam logic [7:0] CMD_PWR_MODE   = 8'h0A;
  localparam logic [7:0] CMD_ACC_CTL    = 8'h0B;
  localparam logic [7:0] CMD_PIX_FMT    = 8'h0C;
  localparam logic [7:0] CMD_IMG_MODE   = 8'h0D;
  localparam logic [7:0] CMD_SIG_MODE   = 8'h0E;
  localparam logic [7:0] CMD_SELF_DIAG  = 8'h0F;
  localparam logic [7:0] CMD_SLEEP_IN   = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT  = 8'h11;
  localparam logic [7:0] CMD_PART_ON    = 8'h12;
  localparam logic [7:0] CMD_NORMAL     = 8'h13;
  localparam logic [7:0] CMD_INV_OFF    = 8'h20;
  localparam logic [7:0] CMD_INV_ON     = 8'h21;
  localparam logic [7:0] CMD_ALL_BLACK  = 8'h22;
  localparam logic [7:0] CMD_ALL_WHITE  = 8'h23;
  localparam logic [7:0] CMD_GAMMA      = 8'h26;
  localparam logic [7:0] CMD_DISP_OFF   = 8'h28;
  localparam logic [7:0] CMD_DISP_ON    = 8'h29;
  localparam logic [7:0] CMD_COL_WIN    = 8'h2A;
  localparam logic [7:0] CMD_ROW_WIN    = 8'h2B;
  localparam logic [7:0] CMD_PART_AREA  = 8'h30;
  localparam logic [7:0] CMD_CHROMA_LO  = 8'h70;
  localparam logic [7:0] CMD_CHROMA_HI  = 8'h7E;

  localparam logic [2:0] WINDOW_PARAMS  = 3'h4;
  localparam logic [5:0] MAX_PARAMS     = 6'h20;

  localparam logic [7:0]  GAMMA_RESET   = 8'h01;
  localparam logic [15:0] COL_LAST_RST  = 16'h0167;
  localparam logic [15:0] ROW_LAST_RST  = 16'h027F;

  // Status word bit positions.
  localparam int ST_BOOST   = 31;
  localparam int ST_PARTIAL = 21;
  localparam int ST_SLEPT   = 20;
  localparam int ST_NORMAL  = 19;
  localparam int ST_INVERT  = 13;
  localparam int ST_ALLON   = 12;
  localparam int ST_ALLOFF  = 11;
  localparam int ST_DISPLAY_ON_CMD  = 10;

  // Chromaticity table: 15 read bytes.
  localparam int CHROMA_WORDS = 15;
  // Nominal 10-bit codes rounded to the nearest fraction; extra colour is unused.
  localparam logic [9:0] CH_BKX = 10'h0000;
  localparam logic [9:0] CH_BKY = 10'h0000;
  localparam logic [9:0] CH_WX  = 10'h0140;
  localparam logic [9:0] CH_WY  = 10'h0151;
  localparam logic [9:0] CH_RX  = 10'h028F;
  localparam logic [9:0] CH_RY  = 10'h0152;
  localparam logic [9:0] CH_GX  = 10'h0133;
  localparam logic [9:0] CH_GY  = 10'h0265;
  localparam logic [9:0] CH_BX  = 10'h009A;
  localparam logic [9:0] CH_BY  = 10'h003D;
  localparam logic [9:0] CH_AX  = 10'h0000;
  localparam logic [9:0] CH_AY  = 10'h0000;

endpackage

// >>> core/chroma_rom.sv
/*
  Colour characteristic store with a registered byte output.
  Assumes a steady index one cycle ahead.
*/
`timescale 1ns/10ps
`default_nettype none
module chroma_rom
  import disp_cmd_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] index,
  output var  logic [7:0] data_q
);

  // Low-bit byte packs bits [1:0] of four coordinates, first coordinate on top.
  function automatic logic [7:0] lowBits(input logic [9:0] a, input logic [9:0] b,
                                          input logic [9:0] c, input logic [9:0] d);
    return {a[1:0], b[1:0], c[1:0], d[1:0]};
  endfunction

  logic [7:0] table_d;

  always_comb begin
    unique case (index)
      4'h0:    table_d = lowBits(CH_BKX, CH_BKY, CH_WX, CH_WY);
      4'h1:    table_d = CH_BKX[9:2];
      4'h2:    table_d = CH_BKY[9:2];
      4'h3:    table_d = CH_WX[9:2];
      4'h4:    table_d = CH_WY[9:2];
      4'h5:    table_d = lowBits(CH_RX, CH_RY, CH_GX, CH_GY);
      4'h6:    table_d = CH_RX[9:2];
      4'h7:    table_d = CH_RY[9:2];
      4'h8:    table_d = CH_GX[9:2];
      4'h9:    table_d = CH_GY[9:2];
      4'hA:    table_d = lowBits(CH_BX, CH_BY, CH_AX, CH_AY);
      4'hB:    table_d = CH_BX[9:2];
      4'hC:    table_d = CH_BY[9:2];
      4'hD:    table_d = CH_AX[9:2];
      4'hE:    table_d = CH_AY[9:2];
      default: table_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_q <= 8'h00;
    end else begin
      data_q <= table_d;
    end
  end

endmodule
`default_nettype wire

// >>> core/display_command_decoder.sv
/*
  Host command decoder: commands, parameters, readback and display modes.
  Assumes mclk-domain byte strobes and a frame-start pulse.
*/
// Summary of operation
// [RULE_01] Colour coordinates are 10-bit fractions, bit 9 weighs one half.
// [RULE_02] Black, white, red, green, blue supplied; unused extra colour reads zero.
// [RULE_03] Stored coordinates are the nearest 10-bit codes to intended values.
// [RULE_04] Colour characteristics are readable through the host byte interface.
// [RULE_05] Link error read returns one 8-bit error count at once.
// [RULE_06] Codes 06h-08h return red, green, blue of the first pixel.
// [RULE_07] Status read returns 32-bit word as four bytes, high byte first.
// [RULE_08] Packet link addresses each parameter by command and index bytes.
// [RULE_09] Codes 0Ah-0Fh each return one immediate 8-bit mode readback.
// [RULE_10] Sleep entry stops booster and sleeps at the next frame.
// [RULE_11] Sleep exit leaves sleep and starts booster immediately.
// [RULE_12] 12h partial on, 13h normal display, both at next frame.
// [RULE_13] 20h inversion off, 21h inversion on, both at next frame.
// [RULE_14] 22h all black, 23h all white, both at next frame.
// [RULE_15] Gamma select takes one byte, applied at next frame.
// [RULE_16] 28h display off, 29h display on, both at next frame.
// [RULE_17] Column window: start then end, high byte first, applied immediately.
// [RULE_18] Row window: start then end, high byte first, four bytes.
// [RULE_19] Partial area: first then last row, applied at next frame.
// [RULE_20] Frame-synchronous commands act only at the next frame start.
// [RULE_21] Direct commands act once command and all parameters are in.
// [RULE_22] Parameters commit after the last byte; a break discards them.
// [RULE_23] Unknown codes are ignored and leave display state unchanged; they end any parameter or read phase.
`timescale 1ns/10ps
`default_nettype none
module display_command_decoder
  import disp_cmd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cmdStrobe,
  input  wire logic        paramStrobe,
  input  wire logic        readStrobe,
  input  wire logic        packetMode,
  input  wire logic [15:0] packetAddr,
  input  wire logic [7:0]  dataIn,
  input  wire logic        transferBreak,
  input  wire logic        frameStart,
  input  wire logic [7:0]  linkErrorCount,
  input  wire logic [23:0] firstPixel,
  input  wire logic [7:0]  accessControl,
  input  wire logic [7:0]  pixelFormat,
  input  wire logic [7:0]  signalMode,
  input  wire logic [7:0]  selfDiag,
  output var  logic [7:0]  readData_q,
  output var  logic        readValid_q,
  output var  logic        sleepMode_q,
  output var  logic        boosterOn_q,
  output var  logic        partialMode_q,
  output var  logic        inversionOn_q,
  output var  logic        allBlack_q,
  output var  logic        allWhite_q,
  output var  logic        displayOn_q,
  output var  logic [7:0]  curveSelector_q,
  output var  logic [15:0] columnFirst_q,
  output var  logic [15:0] columnLast_q,
  output var  logic [15:0] rowFirst_q,
  output var  logic [15:0] rowLast_q,
  output var  logic [15:0] partialFirstRow_q,
  output var  logic [15:0] partialLastRow_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Command capture and parameter staging.

  typedef enum logic [2:0] {
    IDLE   = 3'b001,
    PARAMS = 3'b010,
    READ   = 3'b100
  } phase_t;

  phase_t      phase_q;
  logic [7:0]  cmd_q;
  logic [5:0]  pIdx_q;
  logic [31:0] stage_q;
  logic        commit;
  logic [5:0]  pIdxUse;
  logic [31:0] stageNext;

  function automatic logic [5:0] paramsOf(input logic [7:0] code);
    unique case (code)
      CMD_GAMMA: return 6'h01;
      CMD_COL_WIN, CMD_ROW_WIN, CMD_PART_AREA: return {3'b000, WINDOW_PARAMS};
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic isRead(input logic [7:0] code);
    return (code >= CMD_LINK_ERR && code <= CMD_SELF_DIAG) ||
           (code >= CMD_CHROMA_LO && code <= CMD_CHROMA_HI);
  endfunction

  // On the packet link the low address byte is the parameter index.
  assign pIdxUse   = packetMode ? packetAddr[5:0] : pIdx_q; // [RULE_08]
  assign stageNext = {stage_q[23:0], dataIn}; // [RULE_17] [RULE_18] [RULE_19]
  assign commit    = (phase_q == PARAMS) && paramStrobe && !transferBreak &&
                     (pIdxUse == paramsOf(cmd_q) - 6'h01);  // [RULE_21] [RULE_22]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_q <= IDLE;
      cmd_q   <= 8'h00;
      pIdx_q  <= 6'h00;
      stage_q <= 32'h0000_0000;
    end else if (cmdStrobe) begin
      cmd_q   <= dataIn;
      pIdx_q  <= 6'h00;
      stage_q <= 32'h0000_0000;
      if (isRead(dataIn)) begin
        phase_q <= READ;
      end else if (paramsOf(dataIn) != 6'h00) begin
        phase_q <= PARAMS;
      end else begin
        phase_q <= IDLE; // [RULE_23]
      end
    end else if (transferBreak) begin
      phase_q <= IDLE; // [RULE_22]
    end else if (phase_q == PARAMS && paramStrobe) begin
      stage_q <= stageNext;
      pIdx_q  <= pIdx_q + 6'h01;
      if (commit || pIdxUse >= MAX_PARAMS - 6'h01) begin
        phase_q <= IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame-synchronous pending updates.

  logic        pendSleep_q, pendPart_q, pendNorm_q;
  logic        pendInvOff_q, pendInvOn_q, pendBlack_q, pendWhite_q;
  logic        pendDOff_q, pendDOn_q, pendGamma_q, pendArea_q;
  logic [7:0]  gammaHold_q;
  logic [31:0] areaHold_q;
  logic        noParamCmd;

  assign noParamCmd = cmdStrobe && !isRead(dataIn) && paramsOf(dataIn) == 6'h00;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {pendSleep_q, pendPart_q, pendNorm_q, pendInvOff_q, pendInvOn_q} <= 5'h00;
      {pendBlack_q, pendWhite_q, pendDOff_q, pendDOn_q} <= 4'h0;
      pendGamma_q <= 1'b0;
      pendArea_q  <= 1'b0;
      gammaHold_q <= GAMMA_RESET;
      areaHold_q  <= 32'h0000_0000;
    end else begin
      // A request landing in the frame-start cycle waits for the next frame.
      if (frameStart) begin // [RULE_20]
        {pendSleep_q, pendPart_q, pendNorm_q, pendInvOff_q, pendInvOn_q} <= 5'h00;
        {pendBlack_q, pendWhite_q, pendDOff_q, pendDOn_q} <= 4'h0;
        pendGamma_q <= 1'b0;
        pendArea_q  <= 1'b0;
      end
      if (noParamCmd) begin
        unique case (dataIn)
          CMD_SLEEP_IN: pendSleep_q <= 1'b1; // [RULE_10]
          CMD_SLEEP_OUT: pendSleep_q <= 1'b0; // [RULE_11]
          CMD_PART_ON: begin pendPart_q <= 1'b1; pendNorm_q <= 1'b0; end // [RULE_12]
          CMD_NORMAL: begin pendNorm_q <= 1'b1; pendPart_q <= 1'b0; end // [RULE_12]
          CMD_INV_OFF: begin pendInvOff_q <= 1'b1; pendInvOn_q <= 1'b0; end // [RULE_13]
          CMD_INV_ON: begin pendInvOn_q <= 1'b1; pendInvOff_q <= 1'b0; end // [RULE_13]
          CMD_ALL_BLACK: begin pendBlack_q <= 1'b1; pendWhite_q <= 1'b0; end // [RULE_14]
          CMD_ALL_WHITE: begin pendWhite_q <= 1'b1; pendBlack_q <= 1'b0; end // [RULE_14]
          CMD_DISP_OFF: begin pendDOff_q <= 1'b1; pendDOn_q <= 1'b0; end // [RULE_16]
          CMD_DISP_ON: begin pendDOn_q <= 1'b1; pendDOff_q <= 1'b0; end // [RULE_16]
          default: ; // [RULE_23]
        endcase
      end
      if (commit && cmd_q == CMD_GAMMA) begin
        pendGamma_q <= 1'b1; // [RULE_15]
        gammaHold_q <= dataIn;
      end
      if (commit && cmd_q == CMD_PART_AREA) begin
        pendArea_q <= 1'b1; // [RULE_19]
        areaHold_q <= stageNext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied display state.

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sleepMode_q       <= 1'b1;
      boosterOn_q       <= 1'b0;
      partialMode_q     <= 1'b0;
      inversionOn_q     <= 1'b0;
      allBlack_q        <= 1'b0;
      allWhite_q        <= 1'b0;
      displayOn_q       <= 1'b0;
      curveSelector_q   <= GAMMA_RESET;
      partialFirstRow_q <= 16'h0000;
      partialLastRow_q  <= ROW_LAST_RST;
    end else begin
      // Sleep exit bypasses the frame wait so the booster restarts at once.
      if (noParamCmd && dataIn == CMD_SLEEP_OUT) begin // [RULE_11]
        sleepMode_q <= 1'b0;
        boosterOn_q <= 1'b1;
      end else if (frameStart && pendSleep_q) begin // [RULE_10] [RULE_20]
        sleepMode_q <= 1'b1;
        boosterOn_q <= 1'b0;
      end
      if (frameStart) begin // [RULE_20]
        if (pendPart_q) partialMode_q <= 1'b1; // [RULE_12]
        if (pendNorm_q) partialMode_q <= 1'b0; // [RULE_12]
        if (pendInvOn_q) inversionOn_q <= 1'b1; // [RULE_13]
        if (pendInvOff_q) inversionOn_q <= 1'b0; // [RULE_13]
        if (pendBlack_q) begin allBlack_q <= 1'b1; allWhite_q <= 1'b0; end // [RULE_14]
        if (pendWhite_q) begin allWhite_q <= 1'b1; allBlack_q <= 1'b0; end // [RULE_14]
        if (pendDOn_q) displayOn_q <= 1'b1; // [RULE_16]
        if (pendDOff_q) displayOn_q <= 1'b0; // [RULE_16]
        if (pendGamma_q) curveSelector_q <= gammaHold_q; // [RULE_15]
        if (pendArea_q) begin // [RULE_19]
          partialFirstRow_q <= areaHold_q[31:16];
          partialLastRow_q  <= areaHold_q[15:0];
        end
      end
    end
  end

  // Window registers update directly on the last parameter.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      columnFirst_q <= 16'h0000;
      columnLast_q  <= COL_LAST_RST;
      rowFirst_q    <= 16'h0000;
      rowLast_q     <= ROW_LAST_RST;
    end else if (commit && cmd_q == CMD_COL_WIN) begin // [RULE_17] [RULE_21]
      columnFirst_q <= stageNext[31:16];
      columnLast_q  <= stageNext[15:0];
    end else if (commit && cmd_q == CMD_ROW_WIN) begin // [RULE_18] [RULE_21]
      rowFirst_q <= stageNext[31:16];
      rowLast_q  <= stageNext[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback path.

  logic [31:0] statusWord;
  logic [7:0]  powerMode, imageMode, chromaData;
  logic [3:0]  chromaIndex;
  logic [7:0]  readMux;
  logic [1:0]  rdIdx_q;

  always_comb begin
    statusWord             = 32'h0000_0000;
    statusWord[ST_BOOST]   = boosterOn_q;
    statusWord[ST_PARTIAL] = partialMode_q;
    statusWord[ST_SLEPT]   = !sleepMode_q;
    statusWord[ST_NORMAL]  = !partialMode_q;
    statusWord[ST_INVERT]  = inversionOn_q;
    statusWord[ST_ALLON]   = allWhite_q;
    statusWord[ST_ALLOFF]  = allBlack_q;
    statusWord[ST_DISPLAY_ON_CMD]  = displayOn_q;
  end

  assign powerMode   = {boosterOn_q, 2'b00, !sleepMode_q, !partialMode_q, displayOn_q, 2'b00};
  assign imageMode   = {2'b00, inversionOn_q, 2'b00, curveSelector_q[2:0]};
  // The index comes from the held command code, so the registered store has settled one cycle after it.
  assign chromaIndex = 4'(cmd_q - CMD_CHROMA_LO);

  chroma_rom u_chroma (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .index  (chromaIndex),
    .data_q (chromaData)
  ); // [RULE_01] [RULE_02] [RULE_03]

  always_comb begin
    unique case (cmd_q)
      CMD_LINK_ERR: readMux = linkErrorCount; // [RULE_05]
      CMD_PIX_RED: readMux = firstPixel[23:16]; // [RULE_06]
      CMD_PIX_GREEN: readMux = firstPixel[15:8]; // [RULE_06]
      CMD_PIX_BLUE: readMux = firstPixel[7:0]; // [RULE_06]
      CMD_STATUS: readMux = statusWord[8*(3-rdIdx_q) +: 8]; // [RULE_07]
      CMD_PWR_MODE: readMux = powerMode; // [RULE_09]
      CMD_ACC_CTL: readMux = accessControl; // [RULE_09]
      CMD_PIX_FMT: readMux = pixelFormat; // [RULE_09]
      CMD_IMG_MODE: readMux = imageMode; // [RULE_09]
      CMD_SIG_MODE: readMux = signalMode; // [RULE_09]
      CMD_SELF_DIAG: readMux = selfDiag; // [RULE_09]
      default: readMux = chromaData; // [RULE_04]
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdIdx_q     <= 2'b00;
      readData_q  <= 8'h00;
      readValid_q <= 1'b0;
    end else begin
      readValid_q <= 1'b0;
      if (cmdStrobe) begin
        rdIdx_q <= 2'b00;
      end else if (phase_q == READ && readStrobe) begin
        readData_q  <= readMux;
        readValid_q <= 1'b1;
        if (cmd_q == CMD_STATUS) begin
          rdIdx_q <= rdIdx_q + 2'b01; // [RULE_07]
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> test/host_model.sv
/* Host model: drives command, parameter and read strobes.
   Assumes sampling on the rising mclk edge. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic        readValid_q,
  input  wire logic [7:0]  readData_q,
  output var  logic        cmdStrobe,
  output var  logic        paramStrobe,
  output var  logic        readStrobe,
  output var  logic        packetMode,
  output var  logic [15:0] packetAddr,
  output var  logic [7:0]  dataIn
);
  initial begin
    {cmdStrobe, paramStrobe, readStrobe, packetMode} = 4'h0;
    packetAddr = 16'h0000;
    dataIn = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Kind 0 is a command, 1 a parameter, 2 a parameter addressed by packet.
  // A released byte line shows the inverse, never a stale byte.
  task automatic put(input logic [1:0] kind, input logic [7:0] b, input logic [15:0] a);
    @(negedge mclk);
    dataIn = b;
    packetAddr = a;
    packetMode = kind == 2'h2;
    cmdStrobe = kind == 2'h0;
    paramStrobe = kind != 2'h0;
    @(negedge mclk);
    {cmdStrobe, paramStrobe} = 2'h0;
    dataIn = ~b;
  endtask
  task automatic get(output logic [7:0] b, output logic ok);
    @(negedge mclk);
    readStrobe = 1'b1;
    @(negedge mclk);
    readStrobe = 1'b0;
    ok = 1'b0;
    b = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (readValid_q === 1'b1) begin
        b = readData_q;
        ok = 1'b1;
      end else
        @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// >>> test/display_command_decoder_properties.sv
/* Port checker of the command decoder.
   Assumes one clock, mclk, and synchronous active-low rst_n. */
`timescale 1ns/10ps
`default_nettype none
module display_command_decoder_properties
  import disp_cmd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cmdStrobe,
  input  wire logic        paramStrobe,
  input  wire logic        readStrobe,
  input  wire logic [7:0]  dataIn,
  input  wire logic        frameStart,
  input  wire logic        readValid_q,
  input  wire logic [7:0]  readData_q,
  input  wire logic        sleepMode_q,
  input  wire logic        boosterOn_q,
  input  wire logic        inversionOn_q,
  input  wire logic        displayOn_q,
  input  wire logic [7:0]  curveSelector_q,
  input  wire logic        partialMode_q,
  input  wire logic [15:0] partialFirstRow_q,
  input  wire logic [15:0] columnFirst_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_sleep_exit;
    cmdStrobe && dataIn == CMD_SLEEP_OUT |-> ##[1:2] !sleepMode_q && boosterOn_q;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit late");
  property p_booster_pair;
    boosterOn_q != sleepMode_q;
  endproperty
  a_booster_pair: assert property (p_booster_pair) else $error("booster and sleep disagree");
  property p_sleep_frame;
    $rose(sleepMode_q) |-> $past(frameStart);
  endproperty
  a_sleep_frame: assert property (p_sleep_frame) else $error("sleep entered off frame");
  property p_disp_frame;
    $changed(displayOn_q) |-> $past(frameStart);
  endproperty
  a_disp_frame: assert property (p_disp_frame) else $error("display state off frame");
  property p_inv_frame;
    $changed(inversionOn_q) |-> $past(frameStart);
  endproperty
  a_inv_frame: assert property (p_inv_frame) else $error("inversion off frame");
  property p_curve_frame;
    $changed(curveSelector_q) |-> $past(frameStart);
  endproperty
  a_curve_frame: assert property (p_curve_frame) else $error("curve off frame");
  property p_part_frame;
    $changed({partialMode_q, partialFirstRow_q}) |-> $past(frameStart);
  endproperty
  a_part_frame: assert property (p_part_frame) else $error("partial off frame");
  property p_col_direct;
    $changed(columnFirst_q) |-> $past(paramStrobe);
  endproperty
  a_col_direct: assert property (p_col_direct) else $error("column window off param");
  property p_read_cause;
    readValid_q |-> $past(readStrobe);
  endproperty
  a_read_cause: assert property (p_read_cause) else $error("read byte unasked");
  property p_read_stands;
    !readValid_q |-> $stable(readData_q);
  endproperty
  a_read_stands: assert property (p_read_stands) else $error("read byte moved");
  c_disp: cover property (frameStart ##[1:2] $rose(displayOn_q));
  c_read: cover property (readStrobe ##[1:2] readValid_q);
  c_col: cover property ($changed(columnFirst_q));
endmodule
bind display_command_decoder display_command_decoder_properties chk_u (.mclk, .rst_n, .cmdStrobe, .paramStrobe,
  .readStrobe, .dataIn, .frameStart, .readValid_q, .readData_q, .sleepMode_q, .boosterOn_q, .inversionOn_q,
  .displayOn_q, .curveSelector_q, .partialMode_q, .partialFirstRow_q, .columnFirst_q);
`default_nettype wire

// >>> test/test_display_command_decoder.sv
/* Bench of the command decoder with the host model.
   Assumes a 25 MHz mclk; frame pulses come from here. */
`timescale 1ns/10ps
`default_nettype none
module test_display_command_decoder
  import disp_cmd_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        frameStart = 1'b0;
  logic        transferBreak = 1'b0;
  logic [7:0]  linkErrorCount = 8'hA5;
  logic [23:0] firstPixel = 24'h1A_2B3C;
  logic [7:0]  accessControl = 8'h5A;
  logic [7:0]  pixelFormat = 8'h66;
  logic [7:0]  signalMode = 8'h81;
  logic [7:0]  selfDiag = 8'hC0;
  logic        cmdStrobe, paramStrobe, readStrobe, packetMode, readValid_q;
  logic [15:0] packetAddr;
  logic [7:0]  dataIn, readData_q, curveSelector_q;
  logic        sleepMode_q, boosterOn_q, partialMode_q, inversionOn_q, allBlack_q, allWhite_q, displayOn_q;
  logic [15:0] columnFirst_q, columnLast_q, rowFirst_q, rowLast_q, partialFirstRow_q, partialLastRow_q;
  logic [6:0]  ms = 7'h40;
  int          nFail = 0;
  int          checked = 0;
  always #20 mclk = ~mclk;
  display_command_decoder dut_u (.mclk, .rst_n, .cmdStrobe, .paramStrobe, .readStrobe, .packetMode,
    .packetAddr, .dataIn, .transferBreak, .frameStart, .linkErrorCount, .firstPixel, .accessControl,
    .pixelFormat, .signalMode, .selfDiag, .readData_q, .readValid_q, .sleepMode_q, .boosterOn_q,
    .partialMode_q, .inversionOn_q, .allBlack_q, .allWhite_q, .displayOn_q, .curveSelector_q,
    .columnFirst_q, .columnLast_q, .rowFirst_q, .rowLast_q, .partialFirstRow_q, .partialLastRow_q);
  host_model host_u (.mclk, .readValid_q, .readData_q, .cmdStrobe, .paramStrobe, .readStrobe,
    .packetMode, .packetAddr, .dataIn);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Mode vector order: sleep, booster, partial, inversion, black, white, display.
  function automatic logic [6:0] upd(input logic [6:0] s, input logic [7:0] c);
    case (c)
      CMD_SLEEP_IN: s[6:5] = 2'b10;
      CMD_SLEEP_OUT: s[6:5] = 2'b01;
      CMD_PART_ON: s[4] = 1'b1;
      CMD_NORMAL: s[4] = 1'b0;
      CMD_INV_OFF: s[3] = 1'b0;
      CMD_INV_ON: s[3] = 1'b1;
      CMD_ALL_BLACK: s[2:1] = 2'b10;
      CMD_ALL_WHITE: s[2:1] = 2'b01;
      CMD_DISP_OFF: s[0] = 1'b0;
      CMD_DISP_ON: s[0] = 1'b1;
      default: ;
    endcase
    return s;
  endfunction
  function automatic logic [7:0] rexp(input logic [7:0] c);
    case (c)
      CMD_LINK_ERR: return linkErrorCount;
      CMD_PIX_RED: return firstPixel[23:16];
      CMD_PIX_GREEN: return firstPixel[15:8];
      CMD_PIX_BLUE: return firstPixel[7:0];
      CMD_PWR_MODE: return {ms[5], 2'b00, !ms[6], !ms[4], ms[0], 2'b00};
      CMD_ACC_CTL: return accessControl;
      CMD_PIX_FMT: return pixelFormat;
      CMD_IMG_MODE: return {2'b00, ms[3], 2'b00, 3'h4};
      CMD_SIG_MODE: return signalMode;
      default: return selfDiag;
    endcase
  endfunction
  function automatic logic [7:0] chroma(input int k);
    logic [9:0] c[12];
    int g;
    c = '{CH_BKX, CH_BKY, CH_WX, CH_WY, CH_RX, CH_RY, CH_GX, CH_GY, CH_BX, CH_BY, CH_AX, CH_AY};
    g = 4 * (k / 5);
    if (k % 5 == 0)
      return {c[g][1:0], c[g + 1][1:0], c[g + 2][1:0], c[g + 3][1:0]};
    return c[g + k % 5 - 1][9:2];
  endfunction
  task automatic cmd(input logic [7:0] c);
    host_u.put(2'h0, c, {c, 8'h00});
  endtask
  task automatic fr();
    @(negedge mclk) frameStart = 1'b1;
    @(negedge mclk) frameStart = 1'b0;
    @(negedge mclk);
  endtask
  task automatic chkst();
    chk("modes", {sleepMode_q, boosterOn_q, partialMode_q, inversionOn_q, allBlack_q, allWhite_q, displayOn_q}, ms);
  endtask
  // Sends n bytes of v, high byte first.
  task automatic sendw(input logic [7:0] c, input logic [31:0] v, input int n, input logic [1:0] kind);
    cmd(c);
    for (int i = 0; i < n; i++)
      host_u.put(kind, v[31 - 8 * i -: 8], {c, 8'(i)});
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [31:0] e, input int nb);
    logic [7:0] b;
    logic ok;
    cmd(c);
    @(negedge mclk);
    for (int i = nb - 1; i >= 0; i--) begin
      host_u.get(b, ok);
      if (!ok) begin
        nFail++;
        wrap_up();
      end
      chk("readData_q", b, e[8 * i +: 8]);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    logic [7:0] codes[10];
    codes = '{CMD_SLEEP_OUT, CMD_DISP_ON, CMD_INV_ON, CMD_ALL_BLACK, CMD_ALL_WHITE, CMD_PART_ON,
              CMD_NORMAL, CMD_INV_OFF, CMD_DISP_OFF, CMD_SLEEP_IN};
    chkst();
    chk("curve", curveSelector_q, GAMMA_RESET);
    chk("colLast", columnLast_q, COL_LAST_RST);
    foreach (codes[i]) begin
      cmd(codes[i]);
      @(negedge mclk);
      if (codes[i] != CMD_SLEEP_OUT) begin
        chkst();
        fr();
      end
      ms = upd(ms, codes[i]);
      chkst();
    end
    sendw(CMD_GAMMA, 32'h0400_0000, 1, 2'h1);
    chk("curve", curveSelector_q, GAMMA_RESET);
    fr();
    chk("curve", curveSelector_q, 8'h04);
    $display("modes done");
  endtask
  task automatic t_windows();
    sendw(CMD_COL_WIN, 32'h0012_0145, 4, 2'h1);
    chk("colWin", {columnFirst_q, columnLast_q}, 32'h0012_0145);
    sendw(CMD_ROW_WIN, 32'h0003_0200, 4, 2'h2);
    chk("rowWin", {rowFirst_q, rowLast_q}, 32'h0003_0200);
    sendw(CMD_COL_WIN, 32'h0707_0000, 2, 2'h1);
    @(negedge mclk) transferBreak = 1'b1;
    @(negedge mclk) transferBreak = 1'b0;
    fr();
    chk("colWin", {columnFirst_q, columnLast_q}, 32'h0012_0145);
    sendw(CMD_PART_AREA, 32'h0010_0020, 4, 2'h1);
    chk("partArea", partialFirstRow_q, 16'h0000);
    fr();
    chk("partArea", {partialFirstRow_q, partialLastRow_q}, 32'h0010_0020);
    sendw(8'h55, 32'h7700_0000, 1, 2'h1);
    fr();
    chkst();
    chk("curve", curveSelector_q, 8'h04);
    $display("windows done");
  endtask
  task automatic t_reads();
    for (logic [7:0] c = CMD_LINK_ERR; c <= CMD_SELF_DIAG; c++)
      if (c != CMD_STATUS)
        rd(c, {24'h0, rexp(c)}, 1);
    rd(CMD_STATUS, {ms[5], 9'h0, ms[4], !ms[6], !ms[4], 5'h0, ms[3], ms[1], ms[2], ms[0], 10'h0}, 4);
    for (int k = 0; k < CHROMA_WORDS; k++)
      rd(CMD_CHROMA_LO + 8'(k), {24'h0, chroma(k)}, 1);
    rd(8'h76, 32'h0000_00A3, 1);
    rd(CMD_CHROMA_HI, 32'h0000_0000, 1);
    $display("reads done");
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    nFail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    t_modes();
    t_windows();
    t_reads();
    wrap_up();
  end
endmodule
`default_nettype wire
